// File: verilog/cpmc_pkg.sv
/*
  Constants shared by the clock and power mode control block: register byte
  addresses, unlock key values, reset values, field positions and mode codes.
  Assumes a 32-bit APB address bus that decodes the full address.
*/
package cpmc_pkg;

  // ==========================================================================
  // Register byte addresses
  localparam logic [31:0] CPMC_ADDR_PWR_KEY1 = 32'hffff0404;
  localparam logic [31:0] CPMC_ADDR_PWR_MODE = 32'hffff0408;
  localparam logic [31:0] CPMC_ADDR_PWR_KEY2 = 32'hffff040c;
  localparam logic [31:0] CPMC_ADDR_CLK_KEY1 = 32'hffff0410;
  localparam logic [31:0] CPMC_ADDR_CLK_SRC = 32'hffff0414;
  localparam logic [31:0] CPMC_ADDR_CLK_KEY2 = 32'hffff0418;
  localparam logic [31:0] CPMC_ADDR_PWR_KEY3 = 32'hffff0434;
  localparam logic [31:0] CPMC_ADDR_PER_CLK = 32'hffff0438;
  localparam logic [31:0] CPMC_ADDR_PWR_KEY4 = 32'hffff043c;
  localparam logic [31:0] CPMC_ADDR_STATUS = 32'hffff0440;

  // ==========================================================================
  // Unlock key values
  localparam logic [15:0] CPMC_KEY_CLK_OPEN = 16'h00aa;
  localparam logic [15:0] CPMC_KEY_CLK_SHUT = 16'h0055;
  localparam logic [15:0] CPMC_KEY_PM_OPEN = 16'h0001;
  localparam logic [15:0] CPMC_KEY_PM_SHUT = 16'h00f4;
  localparam logic [15:0] CPMC_KEY_PER_OPEN = 16'h0076;
  localparam logic [15:0] CPMC_KEY_PER_SHUT = 16'h00b1;

  // ==========================================================================
  // Reset values and writable masks
  localparam logic [7:0] CPMC_CLK_SRC_RST = 8'h21;
  localparam logic [7:0] CPMC_PWR_MODE_RST = 8'h00;
  localparam logic [15:0] CPMC_PER_CLK_RST = 16'h0004;
  localparam logic [7:0] CPMC_CLK_SRC_MASK = 8'h23;
  localparam logic [7:0] CPMC_PWR_MODE_MASK = 8'h77;
  localparam logic [15:0] CPMC_PER_CLK_MASK = 16'h01ff;

  // ==========================================================================
  // Field positions
  localparam int CPMC_INT_OSC_BIT = 5;
  localparam int CPMC_MODE_LSB = 4;
  localparam int CPMC_SPI_PO_BIT = 8;
  localparam int CPMC_SPI_DIV_LSB = 6;
  localparam int CPMC_TW2_PO_BIT = 5;
  localparam int CPMC_TW2_DIV_LSB = 3;
  localparam int CPMC_TW1_PO_BIT = 2;
  localparam int CPMC_TW1_DIV_LSB = 0;

  // ==========================================================================
  // Mode codes
  localparam logic [1:0] CPMC_CLKMODE_PLL = 2'h1;
  localparam logic [1:0] CPMC_CLKMODE_EXT = 2'h3;
  localparam logic [2:0] CPMC_OP_ACTIVE = 3'h0;
  localparam logic [2:0] CPMC_OP_PAUSE = 3'h1;
  localparam logic [2:0] CPMC_OP_NAP = 3'h2;
  localparam logic [2:0] CPMC_OP_SLEEP = 3'h3;
  localparam logic [2:0] CPMC_OP_STOP = 3'h4;

  // Protected register targets of the unlock sequence
  typedef enum logic [1:0] {
    CPMC_TGT_CLK,
    CPMC_TGT_PM,
    CPMC_TGT_PER
  } cpmc_tgt_type;

endpackage

// File: verilog/cpmc_tick_gen.sv
/*
  Clock enable generator: one pulse every 2**exp_i clocks, gated.
  Assumes exp_i is steady from a register in the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module cpmc_tick_gen #(
  parameter int CNT_W = 7
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic [2:0] exp_i,
  input wire logic gate_i,
  // Enable pulse
  output logic tick_o
);

  logic [CNT_W-1:0] cnt_q;
  logic tick_q;
  logic [CNT_W-1:0] mask;
  logic hit;

  // Refuse a counter too short for the slowest rate, divide by 128
  if (CNT_W < 7) begin : g_cnt_w_check
    $error("CNT_W must cover an exponent of 7");
  end

  // Low exp_i bits all ones marks the last clock of a period
  assign mask = CNT_W'((1 << exp_i) - 1);
  assign hit = (cnt_q & mask) == mask;
  assign tick_o = tick_q;

  // Free-running count; gating only blanks the pulse, phase is kept
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      tick_q <= hit & gate_i;
    end
  end

endmodule
`default_nettype wire

// File: verilog/cpmc_ctrl.sv
/*
  Clock and power mode control: keyed control registers on APB, operating
  mode with interrupt wake, and gated clock enables for core and peripherals.
  Assumes one 200 MHz clock standing in for the PLL clock; lock and wake
  inputs are asynchronous and are synchronised here.

*/
`timescale 1ns/1ps
`default_nettype none
module cpmc_ctrl
  import cpmc_pkg::*;
#(
  parameter int CNT_W = 7
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Asynchronous inputs
  input wire logic pll_lock_i,
  input wire logic [3:0] ext_irq_i,
  // Clock source and mode
  output logic internal_osc_select_o,
  output logic [1:0] clocking_mode_field_o,
  output logic [2:0] operating_mode_field_o,
  // Clock enables, power and PLL interrupt
  output logic core_clk_en_o,
  output logic serial_port_clk_en_o,
  output logic first_twowire_clk_en_o,
  output logic second_twowire_clk_en_o,
  output logic serial_port_power_on_o,
  output logic first_twowire_power_on_o,
  output logic second_twowire_power_on_o,
  output logic pll_irq_o
);

  typedef enum logic [1:0] {
    CPMC_SEQ_IDLE,
    CPMC_SEQ_ARMED,
    CPMC_SEQ_HELD
  } cpmc_seq_type;

  cpmc_seq_type seq_q, seq_d;
  cpmc_tgt_type tgt_q, tgt_d;
  logic [15:0] held_q, held_d;
  logic [7:0] clk_src_q;
  logic [7:0] pmode_q;
  logic [15:0] pclk_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;
  logic [1:0] lock_sync_q;
  logic [3:0] irq_s1_q, irq_s2_q;
  logic lock_prev_q, lost_q, pll_irq_q;
  logic int_osc_q, out_spo_q, out_t1_q, out_t2_q;
  logic [1:0] out_cm_q;
  logic [2:0] out_op_q;

  // ==========================================================================
  // Input synchronisers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_sync_q <= 2'h0;
      irq_s1_q <= 4'h0;
      irq_s2_q <= 4'h0;
    end else begin
      lock_sync_q <= {lock_sync_q[0], pll_lock_i};
      irq_s1_q <= ext_irq_i;
      irq_s2_q <= irq_s1_q;
    end
  end

  logic lock_s;
  assign lock_s = lock_sync_q[1];

  // ==========================================================================
  // APB decode
  logic setup, wr_acc;
  logic [15:0] wkey;
  logic hit_pk1, hit_pm, hit_pk2, hit_ck1, hit_cs, hit_ck2;
  logic hit_pk3, hit_per, hit_pk4, hit_st, hit_key, hit_any;
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite & pready_q;
  assign wkey = pwdata[15:0];
  assign hit_pk1 = paddr == CPMC_ADDR_PWR_KEY1;
  assign hit_pm = paddr == CPMC_ADDR_PWR_MODE;
  assign hit_pk2 = paddr == CPMC_ADDR_PWR_KEY2;
  assign hit_ck1 = paddr == CPMC_ADDR_CLK_KEY1;
  assign hit_cs = paddr == CPMC_ADDR_CLK_SRC;
  assign hit_ck2 = paddr == CPMC_ADDR_CLK_KEY2;
  assign hit_pk3 = paddr == CPMC_ADDR_PWR_KEY3;
  assign hit_per = paddr == CPMC_ADDR_PER_CLK;
  assign hit_pk4 = paddr == CPMC_ADDR_PWR_KEY4;
  assign hit_st = paddr == CPMC_ADDR_STATUS;
  assign hit_key = hit_pk1 | hit_pk2 | hit_ck1 | hit_ck2 | hit_pk3 | hit_pk4;
  assign hit_any = hit_key | hit_pm | hit_cs | hit_per | hit_st;

  // Read mux; key locations hold nothing readable
  logic [31:0] rd_mux;
  assign rd_mux = hit_cs ? {24'h0, clk_src_q} :
                  hit_pm ? {24'h0, pmode_q} :
                  hit_per ? {16'h0, pclk_q} :
                  hit_st ? {28'h0, seq_q, lost_q, lock_s} : 32'h0;

  // No wait state; read data and response come from flops loaded in the setup cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~hit_any;
      if (setup & ~pwrite) begin
        prdata_q <= rd_mux;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ==========================================================================
  // Unlock sequence: open key, protected write, shut key, back to back
  logic key_open, prot_wr, key_shut, commit;
  logic commit_cs, commit_pm, commit_per;
  cpmc_tgt_type open_tgt;
  assign open_tgt = hit_ck1 ? CPMC_TGT_CLK : hit_pk1 ? CPMC_TGT_PM : CPMC_TGT_PER;
  assign key_open = (hit_ck1 & wkey == CPMC_KEY_CLK_OPEN)
                  | (hit_pk1 & wkey == CPMC_KEY_PM_OPEN)
                  | (hit_pk3 & wkey == CPMC_KEY_PER_OPEN);
  assign prot_wr = (tgt_q == CPMC_TGT_CLK & hit_cs)
                 | (tgt_q == CPMC_TGT_PM & hit_pm)
                 | (tgt_q == CPMC_TGT_PER & hit_per);
  assign key_shut = (tgt_q == CPMC_TGT_CLK & hit_ck2 & wkey == CPMC_KEY_CLK_SHUT)
                  | (tgt_q == CPMC_TGT_PM & hit_pk2 & wkey == CPMC_KEY_PM_SHUT)
                  | (tgt_q == CPMC_TGT_PER & hit_pk4 & wkey == CPMC_KEY_PER_SHUT);
  assign commit = wr_acc & seq_q == CPMC_SEQ_HELD & key_shut;
  assign commit_cs = commit & tgt_q == CPMC_TGT_CLK;
  assign commit_pm = commit & tgt_q == CPMC_TGT_PM;
  assign commit_per = commit & tgt_q == CPMC_TGT_PER;

  // Any other write breaks the chain; reads pass through untouched
  always_comb begin
    seq_d = seq_q;
    tgt_d = tgt_q;
    held_d = held_q;
    if (wr_acc) begin
      seq_d = CPMC_SEQ_IDLE;
      if (seq_q == CPMC_SEQ_ARMED && prot_wr) begin
        seq_d = CPMC_SEQ_HELD;
        held_d = pwdata[15:0];
      end else if (key_open) begin
        seq_d = CPMC_SEQ_ARMED;
        tgt_d = open_tgt;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seq_q <= CPMC_SEQ_IDLE;
      tgt_q <= CPMC_TGT_CLK;
      held_q <= 16'h0;
    end else begin
      seq_q <= seq_d;
      tgt_q <= tgt_d;
      held_q <= held_d;
    end
  end

  // ==========================================================================
  // Protected registers; reserved mode codes leave the old setting in place
  logic cm_ok, op_ok, sleeping, wake;
  assign cm_ok = held_q[1:0] == CPMC_CLKMODE_PLL || held_q[1:0] == CPMC_CLKMODE_EXT;
  assign op_ok = held_q[CPMC_MODE_LSB +: 3] <= CPMC_OP_STOP;
  assign sleeping = pmode_q[CPMC_MODE_LSB +: 3] == CPMC_OP_SLEEP
                  | pmode_q[CPMC_MODE_LSB +: 3] == CPMC_OP_STOP;
  assign wake = sleeping & (|irq_s2_q);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_src_q <= CPMC_CLK_SRC_RST;
      pmode_q <= CPMC_PWR_MODE_RST;
      pclk_q <= CPMC_PER_CLK_RST;
    end else begin
      if (commit_cs && cm_ok) begin
        clk_src_q <= held_q[7:0] & CPMC_CLK_SRC_MASK;
      end
      // Wake beats a same-cycle mode write, so no interrupt is lost
      if (wake) begin
        pmode_q[CPMC_MODE_LSB +: 3] <= CPMC_OP_ACTIVE;
      end else if (commit_pm && op_ok) begin
        pmode_q <= held_q[7:0] & CPMC_PWR_MODE_MASK;
      end
      if (commit_per) begin
        pclk_q <= held_q & CPMC_PER_CLK_MASK;
      end
    end
  end

  // ==========================================================================
  // PLL lock watch; the request shows only once lock is back
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_prev_q <= 1'b0;
      lost_q <= 1'b0;
      pll_irq_q <= 1'b0;
    end else begin
      lock_prev_q <= lock_s;
      // Loss sets over a write-one clear in the same cycle
      if (lock_prev_q & ~lock_s) begin
        lost_q <= 1'b1;
      end else if (wr_acc & hit_st & pwdata[1]) begin
        lost_q <= 1'b0;
      end
      pll_irq_q <= lost_q & lock_s;
    end
  end

  // ==========================================================================
  // Divider exponents and gates
  logic [2:0] mode;
  logic run_core, run_per;
  logic [2:0] exp_core, exp_spi, exp_t1, exp_t2;
  logic [3:0][2:0] exps;
  logic [3:0] gates, ticks;
  assign mode = pmode_q[CPMC_MODE_LSB +: 3];
  assign run_core = mode == CPMC_OP_ACTIVE;
  assign run_per = run_core | mode == CPMC_OP_PAUSE;
  // core divide by two to the field
  assign exp_core = pmode_q[2:0];
  // serial port divide by one to eight
  assign exp_spi = {1'b0, pclk_q[CPMC_SPI_DIV_LSB +: 2]};

  // two-wire codes map to 1, 4, 8, 32
  function automatic logic [2:0] tw_exp(input logic [1:0] code);
    case (code)
      2'h0: tw_exp = 3'h0;
      2'h1: tw_exp = 3'h2;
      2'h2: tw_exp = 3'h3;
      default: tw_exp = 3'h5;
    endcase
  endfunction

  assign exp_t1 = tw_exp(pclk_q[CPMC_TW1_DIV_LSB +: 2]);
  assign exp_t2 = tw_exp(pclk_q[CPMC_TW2_DIV_LSB +: 2]);
  assign exps = {exp_t2, exp_t1, exp_spi, exp_core};
  assign gates[0] = run_core & lock_s;
  assign gates[1] = run_per & pclk_q[CPMC_SPI_PO_BIT];
  assign gates[2] = run_per & pclk_q[CPMC_TW1_PO_BIT];
  assign gates[3] = run_per & pclk_q[CPMC_TW2_PO_BIT];

  // One enable generator per clocked consumer
  for (genvar g = 0; g < 4; g++) begin : g_tick
    cpmc_tick_gen #(
      .CNT_W(CNT_W)
    ) u_tick (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .exp_i(exps[g]),
      .gate_i(gates[g]),
      .tick_o(ticks[g])
    );
  end

  assign core_clk_en_o = ticks[0];
  assign serial_port_clk_en_o = ticks[1];
  assign first_twowire_clk_en_o = ticks[2];
  assign second_twowire_clk_en_o = ticks[3];

  // ==========================================================================
  // Registered copies of the control fields
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      int_osc_q <= 1'b1;
      out_cm_q <= CPMC_CLKMODE_PLL;
      out_op_q <= CPMC_OP_ACTIVE;
      out_spo_q <= 1'b0;
      out_t1_q <= 1'b1;
      out_t2_q <= 1'b0;
    end else begin
      int_osc_q <= clk_src_q[CPMC_INT_OSC_BIT];
      out_cm_q <= clk_src_q[1:0];
      out_op_q <= mode;
      out_spo_q <= pclk_q[CPMC_SPI_PO_BIT];
      out_t1_q <= pclk_q[CPMC_TW1_PO_BIT];
      out_t2_q <= pclk_q[CPMC_TW2_PO_BIT];
    end
  end

  assign internal_osc_select_o = int_osc_q;
  assign clocking_mode_field_o = out_cm_q;
  assign operating_mode_field_o = out_op_q;
  assign serial_port_power_on_o = out_spo_q;
  assign first_twowire_power_on_o = out_t1_q;
  assign second_twowire_power_on_o = out_t2_q;
  assign pll_irq_o = pll_irq_q;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_clk_src_guard: assert property ($changed(clk_src_q) |-> $past(commit_cs))
    else $error("clock source changed without unlock");
  a_pwr_mode_guard: assert property (
    $changed(pmode_q) && !$past(wake) |-> $past(commit_pm))
    else $error("power mode changed without unlock");
  a_per_clk_guard: assert property ($changed(pclk_q) |-> $past(commit_per))
    else $error("peripheral clock changed without unlock");
  a_key_read_zero: assert property (
    setup && !pwrite && hit_key |=> prdata == 32'h0 && pready)
    else $error("key location read nonzero");
  a_op_mode_legal: assert property (mode <= CPMC_OP_STOP)
    else $error("reserved operating mode held");
  a_clk_mode_legal: assert property (
    clk_src_q[1:0] == CPMC_CLKMODE_PLL || clk_src_q[1:0] == CPMC_CLKMODE_EXT)
    else $error("reserved clocking mode held");
  a_wake_to_active: assert property (wake |=> mode == CPMC_OP_ACTIVE ##1
    operating_mode_field_o == CPMC_OP_ACTIVE)
    else $error("no wake from sleep or stop");
  a_core_halt_nolock: assert property (!lock_s |=> !core_clk_en_o)
    else $error("core clock ran without lock");
  a_spi_power_off: assert property (!pclk_q[CPMC_SPI_PO_BIT] |=> !serial_port_clk_en_o)
    else $error("serial port clocked while off");
  a_broken_chain: assert property (
    seq_q == CPMC_SEQ_HELD && wr_acc && !key_shut |=> seq_q != CPMC_SEQ_HELD && $stable(pclk_q))
    else $error("broken unlock chain not dropped");

endmodule
`default_nettype wire

// File: bench/cpmc_ctrl_tb_top.sv
/*
  Self-checking bench for cpmc_ctrl: keyed writes, mode codes, wake,
  lock loss and clock enable rates; registers through APB tasks, irq and lock pins driven directly.
  Assumes every APB transfer ends within a few cycles of its setup.
*/
`timescale 1ns/1ps
`default_nettype none
module cpmc_ctrl_tb_top;
  import cpmc_pkg::*;
  // ==========================
  // Bench signals
  logic clk_i, rst_n_i, psel, penable, pwrite, pll_lock_i;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic pready, pslverr, pll_irq_o, er;
  logic [3:0] ext_irq_i;
  logic int_osc, core_en, sp_en, tw1_en, tw2_en, sp_po, tw1_po, tw2_po;
  logic [1:0] clk_mode;
  logic [2:0] op_mode;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;

  // ==========================
  // Device under test
  cpmc_ctrl DUT (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pll_lock_i(pll_lock_i),
    .ext_irq_i(ext_irq_i), .internal_osc_select_o(int_osc),
    .clocking_mode_field_o(clk_mode), .operating_mode_field_o(op_mode),
    .core_clk_en_o(core_en), .serial_port_clk_en_o(sp_en),
    .first_twowire_clk_en_o(tw1_en), .second_twowire_clk_en_o(tw2_en),
    .serial_port_power_on_o(sp_po), .first_twowire_power_on_o(tw1_po),
    .second_twowire_power_on_o(tw2_po), .pll_irq_o(pll_irq_o)
  );

  // ==========================
  // Clock, 5 ns period
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end

  // ==========================
  // Shared tasks
  task automatic finish_test();
    $display("Checked %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; an idle edge after it keeps drivers single per step
  // Waits for pready however long it takes; only the hang guard ends a stall
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rdchk(input string what, input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
    chk("read error flag", 32'h0, {31'h0, er});
  endtask

  // Open key, protected value, shut key; outputs settle a few edges later
  task automatic keyed(input logic [31:0] ka, input logic [15:0] kv, input logic [31:0] ra,
                       input logic [31:0] v, input logic [31:0] sa, input logic [15:0] sv);
    apb(1'b1, ka, {16'h0, kv});
    apb(1'b1, ra, v);
    apb(1'b1, sa, {16'h0, sv});
    repeat (4) @(posedge clk_i);
  endtask

  task automatic pm(input logic [31:0] v);
    keyed(CPMC_ADDR_PWR_KEY1, 16'h01, CPMC_ADDR_PWR_MODE, v, CPMC_ADDR_PWR_KEY2, 16'hf4);
  endtask

  // Pulse count over a window that is a whole number of periods
  // Four-state sum, so an unknown enable shows up as a mismatch
  task automatic rate(input string what, input int which, input int cycles, input int exp);
    logic [31:0] c;
    c = 32'h0;
    repeat (cycles) begin
      @(posedge clk_i);
      c = c + {31'h0, (which == 0) ? core_en : (which == 1) ? sp_en :
                      (which == 2) ? tw1_en : tw2_en};
    end
    chk(what, exp, c);
  endtask

  // ==========================
  // Scenarios
  // Reset values, key read-back, unmapped access
  task automatic t_reset();
    rdchk("clock source", CPMC_ADDR_CLK_SRC, 32'h21);
    rdchk("power mode", CPMC_ADDR_PWR_MODE, 32'h0);
    rdchk("peripheral clock", CPMC_ADDR_PER_CLK, 32'h4);
    apb(1'b1, CPMC_ADDR_PWR_KEY4, 32'h1234);
    rdchk("key read", CPMC_ADDR_PWR_KEY4, 32'h0);
    apb(1'b0, 32'hffff0400, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, er});
    chk("int osc out", 32'h1, {31'h0, int_osc});
    chk("clock mode out", 32'h1, {30'h0, clk_mode});
    chk("twowire power", 32'h1, {31'h0, tw1_po});
  endtask

  // Every clocking mode code, then wrong keys
  task automatic t_clksrc();
    logic [31:0] v, cur;
    cur = 32'h21;
    for (int m = 0; m < 4; m++) begin
      v = {26'h0, m[1], 3'h0, m[1:0]};
      keyed(CPMC_ADDR_CLK_KEY1, 16'haa, CPMC_ADDR_CLK_SRC, v, CPMC_ADDR_CLK_KEY2, 16'h55);
      if (m[0]) cur = v;
      rdchk("clock source", CPMC_ADDR_CLK_SRC, cur);
      chk("int osc out", {31'h0, cur[5]}, {31'h0, int_osc});
      chk("clock mode out", {30'h0, cur[1:0]}, {30'h0, clk_mode});
    end
    keyed(CPMC_ADDR_CLK_KEY1, 16'hab, CPMC_ADDR_CLK_SRC, 32'h21, CPMC_ADDR_CLK_KEY2, 16'h55);
    rdchk("bad open key", CPMC_ADDR_CLK_SRC, cur);
    keyed(CPMC_ADDR_CLK_KEY1, 16'haa, CPMC_ADDR_CLK_SRC, 32'h21, CPMC_ADDR_CLK_KEY2, 16'h56);
    rdchk("bad shut key", CPMC_ADDR_CLK_SRC, cur);
    keyed(CPMC_ADDR_CLK_KEY1, 16'haa, CPMC_ADDR_CLK_SRC, 32'h21, CPMC_ADDR_CLK_KEY2, 16'h55);
    rdchk("clock source back", CPMC_ADDR_CLK_SRC, 32'h21);
  endtask

  // Operating mode codes, reserved codes, broken sequences
  task automatic t_pm();
    logic [31:0] cur;
    cur = 32'h0;
    for (int m = 0; m < 8; m++) begin
      pm({25'h0, m[2:0], 4'h0});
      if (m < 5) cur = {25'h0, m[2:0], 4'h0};
      rdchk("power mode", CPMC_ADDR_PWR_MODE, cur);
      chk("op mode out", {29'h0, cur[6:4]}, {29'h0, op_mode});
    end
    pm(32'h0);
    // Peripheral value left at 0x1ff by the divider scenario; stray write differs
    apb(1'b1, CPMC_ADDR_PWR_KEY1, 32'h01);
    apb(1'b1, CPMC_ADDR_PWR_MODE, 32'h10);
    apb(1'b1, CPMC_ADDR_PER_CLK, 32'h004);
    apb(1'b1, CPMC_ADDR_PWR_KEY2, 32'hf4);
    rdchk("aborted mode", CPMC_ADDR_PWR_MODE, 32'h0);
    rdchk("unkeyed peripheral", CPMC_ADDR_PER_CLK, 32'h1ff);
    apb(1'b1, CPMC_ADDR_PWR_MODE, 32'h10);
    apb(1'b1, CPMC_ADDR_PWR_KEY2, 32'hf4);
    rdchk("no open key", CPMC_ADDR_PWR_MODE, 32'h0);
    for (int d = 0; d < 8; d++) begin
      pm({29'h0, d[2:0]});
      rate("core rate", 0, 128, 128 >> d);
    end
    pm(32'h10);
    rate("core in pause", 0, 32, 0);
  endtask

  // Power bits and divider codes; core kept slowest for software's side
  task automatic t_per();
    logic [1:0] c;
    pm(32'h07);
    keyed(CPMC_ADDR_PWR_KEY3, 16'h76, CPMC_ADDR_PER_CLK, 32'h0, CPMC_ADDR_PWR_KEY4, 16'hb1);
    chk("power bits", 32'h0, {29'h0, sp_po, tw2_po, tw1_po});
    rate("serial off", 1, 32, 0);
    rate("twowire off", 2, 32, 0);
    for (int k = 0; k < 4; k++) begin
      c = k[1:0];
      keyed(CPMC_ADDR_PWR_KEY3, 16'h76, CPMC_ADDR_PER_CLK,
            {23'h0, 1'b1, c, 1'b1, c, 1'b1, c}, CPMC_ADDR_PWR_KEY4, 16'hb1);
      rdchk("peripheral", CPMC_ADDR_PER_CLK, {23'h0, 1'b1, c, 1'b1, c, 1'b1, c});
      chk("power bits", 32'h7, {29'h0, sp_po, tw2_po, tw1_po});
      rate("serial rate", 1, 64, 64 >> k);
      rate("twowire1 rate", 2, 64, 64 / (k == 0 ? 1 : k == 1 ? 4 : k == 2 ? 8 : 32));
      rate("twowire2 rate", 3, 64, 64 / (k == 0 ? 1 : k == 1 ? 4 : k == 2 ? 8 : 32));
    end
  endtask

  // Each interrupt line wakes sleep or stop; nap ignores it
  task automatic t_wake();
    for (int i = 0; i < 4; i++) begin
      pm(i[0] ? 32'h45 : 32'h35);
      ext_irq_i[i] <= 1'b1;
      repeat (6) @(posedge clk_i);
      chk("woken mode", 32'h0, {29'h0, op_mode});
      rdchk("divider kept", CPMC_ADDR_PWR_MODE, 32'h05);
      ext_irq_i <= 4'h0;
      repeat (4) @(posedge clk_i);
    end
    pm(32'h20);
    ext_irq_i <= 4'h1;
    repeat (6) @(posedge clk_i);
    chk("nap stays", 32'h2, {29'h0, op_mode});
    ext_irq_i <= 4'h0;
    pm(32'h0);
  endtask

  // Lock loss halts the core, interrupt waits for lock, write one clears
  task automatic t_lock();
    pll_lock_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    rate("core unlocked", 0, 16, 0);
    chk("irq while unlocked", 32'h0, {31'h0, pll_irq_o});
    rdchk("status lost", CPMC_ADDR_STATUS, 32'h2);
    pll_lock_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk("irq relocked", 32'h1, {31'h0, pll_irq_o});
    apb(1'b1, CPMC_ADDR_STATUS, 32'h2);
    repeat (3) @(posedge clk_i);
    chk("irq cleared", 32'h0, {31'h0, pll_irq_o});
    rate("core relocked", 0, 16, 16);
  endtask

  // ==========================
  // Main sequence
  initial begin
    rst_n_i = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pll_lock_i = 1'b1;
    ext_irq_i = 4'h0;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    t_reset();
    t_clksrc();
    t_per();
    t_pm();
    t_wake();
    t_lock();
    finish_test();
  end
endmodule
`default_nettype wire
